// file: hw/tops_defs.vh
// Purpose: constants for the timer output controller and prescaler
// Assumes: byte-wide cpu register port, 20 MHz system clock
// Notes: definitions only
`ifndef TOPS_DEFS_VH
`define TOPS_DEFS_VH

// ****************************************
// register addresses
// ****************************************
`define TOPS_ADDR_DIR 16'hFF20
`define TOPS_ADDR_PRE 16'hFFBB
`define TOPS_ADDR_TOC 16'hFFBD

// ****************************************
// reset values
// ****************************************
`define TOPS_RST_DIR 8'hFF
`define TOPS_RST_PRE 8'h00
`define TOPS_RST_TOC 8'h00
`define TOPS_DIR_FIXED 8'hFC

// ****************************************
// output control fields
// ****************************************
`define TOPS_TOC_OSPT 6
`define TOPS_TOC_OSPE 5
`define TOPS_TOC_INV2 4
`define TOPS_TOC_FSET 3
`define TOPS_TOC_FRST 2
`define TOPS_TOC_INV1 1
`define TOPS_TOC_OE 0
`define TOPS_TOC_RMASK 8'h33

// ****************************************
// prescaler fields and timing
// ****************************************
`define TOPS_PRE_B_HI 7
`define TOPS_PRE_B_LO 6
`define TOPS_PRE_A_HI 5
`define TOPS_PRE_A_LO 4
`define TOPS_PRE_CLK_HI 1
`define TOPS_PRE_CLK_LO 0
`define TOPS_EDGE_FALL 2'h0
`define TOPS_EDGE_RISE 2'h1
`define TOPS_EDGE_BOTH 2'h3
`define TOPS_CLK_OSC 2'h0
`define TOPS_CLK_DIV4 2'h1
`define TOPS_CLK_DIV256 2'h2
`define TOPS_CLK_EXT 2'h3
`define TOPS_DIV_W 8
`define TOPS_DIV4_MASK 8'h03
`define TOPS_DIV256_MASK 8'hFF

// ****************************************
// counter modes
// ****************************************
`define TOPS_MODE_STOP 2'h0
`define TOPS_MODE_FREE 2'h1
`define TOPS_MODE_CLR_EDGE 2'h2
`define TOPS_MODE_CLR_MATCH 2'h3

`endif

// file: hw/tops_timer_out.v
// Purpose: timer output flip-flop control, count clock and edge select, pin direction
// Assumes: all inputs synchronous to clock; counter core lives outside
// Notes: counter core reports matches, overflow and its mode on plain inputs
`timescale 1ns/1ps
`include "tops_defs.vh"

// Overview of operation
// - reset clears output control to zero
// - writing one-shot trigger one with bit five set fires pulse
// - bit five selects one-shot pulse mode
// - secondary match inverts flip-flop when enabled
// - force bits set or clear flip-flop
// - primary match inverts flip-flop when enabled
// - output disabled holds pin low
// - one-shot only without clear-on-match mode
// - force and trigger bits read zero
// - prescaler bits 7:6 pick input b edge
// - prescaler bits 5:4 pick input a edge
// - bits 1:0 pick count clock, reset zero
// - high input after reset gives rising edge
// - shared pin is input or output only
// - direction register resets ones, bits 7:2 fixed
// - counter mode chosen by counter control
module tops_timer_out (
    // system
    input wire clock,
    input wire rst,
    // cpu register port
    input wire [15:0] cpu_addr,
    input wire [7:0] cpu_wdata,
    input wire cpu_wr,
    input wire cpu_rd,
    output reg [7:0] cpu_rdata_ff,
    // counter core
    input wire [1:0] counter_mode,
    input wire primary_match,
    input wire secondary_match,
    input wire counter_overflow,
    output reg count_tick_ff,
    output reg input_a_edge_ff,
    output reg input_b_edge_ff,
    // pins
    input wire timer_input_a,
    input wire timer_input_b,
    input wire shared_port_pin1_latch,
    output reg timer_output_pin_ff,
    output reg timer_output_pin_oe_ff,
    output reg [7:0] port0_direction_ff
);

    // ****************************************
    // registers
    // ****************************************
    reg [7:0] timer_output_control_ff;
    reg [7:0] count_clock_edge_select_ff;
    reg timer_output_flipflop_ff;
    reg oneshot_pend_ff;
    reg [`TOPS_DIV_W-1:0] div_ff;
    reg ina_prev_ff;
    reg inb_prev_ff;
    reg running_ff;
    reg [7:0] nxt_rdata;
    reg nxt_tick;
    reg nxt_lv;
    reg toggle;
    wire wr_toc;
    wire wr_pre;
    wire wr_dir;
    wire ina_edge;
    wire inb_edge;
    wire running;
    wire oneshot_fire;

    assign wr_toc = cpu_wr && (cpu_addr == `TOPS_ADDR_TOC);
    assign wr_pre = cpu_wr && (cpu_addr == `TOPS_ADDR_PRE);
    assign wr_dir = cpu_wr && (cpu_addr == `TOPS_ADDR_DIR);
    assign running = (counter_mode != `TOPS_MODE_STOP);

    // ****************************************
    // edge detection
    // ****************************************
    // previous levels start low, so a high input after reset is a rising edge
    function edge_hit;
        input [1:0] sel;
        input prev;
        input cur;
        begin
            case (sel)
                `TOPS_EDGE_FALL: edge_hit = prev & ~cur;
                `TOPS_EDGE_RISE: edge_hit = ~prev & cur;
                `TOPS_EDGE_BOTH: edge_hit = prev ^ cur;
                default: edge_hit = 1'b0;
            endcase
        end
    endfunction

    assign ina_edge = running && edge_hit(count_clock_edge_select_ff[`TOPS_PRE_A_HI:`TOPS_PRE_A_LO],
        ina_prev_ff, timer_input_a);
    assign inb_edge = running && edge_hit(count_clock_edge_select_ff[`TOPS_PRE_B_HI:`TOPS_PRE_B_LO],
        inb_prev_ff, timer_input_b);

    always @(posedge clock) begin
        if (rst) begin
            ina_prev_ff <= 1'b0;
            inb_prev_ff <= 1'b0;
            running_ff <= 1'b0;
            input_a_edge_ff <= 1'b0;
            input_b_edge_ff <= 1'b0;
        end else begin
            running_ff <= running;
            // history holds its last level while stopped, so a pin that rose while stopped gives a rise on restart
            if (running || running_ff) begin
                ina_prev_ff <= timer_input_a;
                inb_prev_ff <= timer_input_b;
            end else begin
                ina_prev_ff <= ina_prev_ff | (running_ff & timer_input_a);
                inb_prev_ff <= inb_prev_ff | (running_ff & timer_input_b);
            end
            input_a_edge_ff <= ina_edge;
            // pin used as output cannot be an edge source
            input_b_edge_ff <= inb_edge && port0_direction_ff[1];
        end
    end

    // ****************************************
    // count clock select
    // ****************************************
    always @* begin
        case (count_clock_edge_select_ff[`TOPS_PRE_CLK_HI:`TOPS_PRE_CLK_LO])
            `TOPS_CLK_OSC: nxt_tick = running;
            `TOPS_CLK_DIV4: nxt_tick = running && ((div_ff & `TOPS_DIV4_MASK) == 8'h00);
            `TOPS_CLK_DIV256: nxt_tick = running && ((div_ff & `TOPS_DIV256_MASK) == 8'h00);
            `TOPS_CLK_EXT: nxt_tick = ina_edge;
            default: nxt_tick = 1'b0;
        endcase
    end

    always @(posedge clock) begin
        if (rst) begin
            div_ff <= 8'h00;
            count_tick_ff <= 1'b0;
        end else begin
            div_ff <= running ? div_ff + 8'h01 : 8'h00;
            count_tick_ff <= nxt_tick;
        end
    end

    // ****************************************
    // output flip-flop
    // ****************************************
    // one-shot needs an overflow, which clear-on-match mode never makes
    assign oneshot_fire = timer_output_control_ff[`TOPS_TOC_OSPE] && oneshot_pend_ff
        && counter_mode != `TOPS_MODE_CLR_MATCH && counter_overflow;

    always @* begin
        toggle = 1'b0;
        if (timer_output_control_ff[`TOPS_TOC_INV1] && primary_match)
            toggle = 1'b1;
        if (timer_output_control_ff[`TOPS_TOC_INV2] && secondary_match)
            toggle = 1'b1;
        if (oneshot_fire)
            toggle = 1'b1;
        // several events in one count cycle give one toggle
        nxt_lv = timer_output_flipflop_ff ^ (toggle && count_tick_ff);
        if (wr_toc) begin
            case ({cpu_wdata[`TOPS_TOC_FSET], cpu_wdata[`TOPS_TOC_FRST]})
                2'h1: nxt_lv = 1'b0;
                2'h2: nxt_lv = 1'b1;
                default: ;
            endcase
        end
    end

    always @(posedge clock) begin
        if (rst) begin
            timer_output_control_ff <= `TOPS_RST_TOC;
            timer_output_flipflop_ff <= 1'b0;
            oneshot_pend_ff <= 1'b0;
        end else begin
            timer_output_flipflop_ff <= nxt_lv;
            if (wr_toc)
                timer_output_control_ff <= cpu_wdata & `TOPS_TOC_RMASK;
            // trigger latches until the next overflow; a new trigger wins over consumption
            if (wr_toc && cpu_wdata[`TOPS_TOC_OSPT] && cpu_wdata[`TOPS_TOC_OSPE])
                oneshot_pend_ff <= 1'b1;
            else if (oneshot_fire && count_tick_ff)
                oneshot_pend_ff <= 1'b0;
            else if (!timer_output_control_ff[`TOPS_TOC_OSPE])
                oneshot_pend_ff <= 1'b0;
        end
    end

    // ****************************************
    // pin and direction
    // ****************************************
    always @(posedge clock) begin
        if (rst) begin
            port0_direction_ff <= `TOPS_RST_DIR;
            timer_output_pin_ff <= 1'b0;
            timer_output_pin_oe_ff <= 1'b0;
        end else begin
            if (wr_dir)
                port0_direction_ff <= cpu_wdata | `TOPS_DIR_FIXED;
            timer_output_pin_oe_ff <= ~port0_direction_ff[1];
            // next enable, like next flip-flop value, so pin never lags the register
            if (wr_toc ? cpu_wdata[`TOPS_TOC_OE] : timer_output_control_ff[`TOPS_TOC_OE])
                timer_output_pin_ff <= nxt_lv & ~shared_port_pin1_latch;
            else
                timer_output_pin_ff <= 1'b0;
        end
    end

    // ****************************************
    // prescaler register and readback
    // ****************************************
    always @(posedge clock) begin
        if (rst)
            count_clock_edge_select_ff <= `TOPS_RST_PRE;
        else if (wr_pre)
            count_clock_edge_select_ff <= cpu_wdata & 8'hF3;
    end

    always @* begin
        case (cpu_addr)
            `TOPS_ADDR_TOC: nxt_rdata = timer_output_control_ff;
            `TOPS_ADDR_PRE: nxt_rdata = count_clock_edge_select_ff;
            `TOPS_ADDR_DIR: nxt_rdata = port0_direction_ff;
            default: nxt_rdata = 8'h00;
        endcase
    end

    always @(posedge clock) begin
        if (rst)
            cpu_rdata_ff <= 8'h00;
        else
            cpu_rdata_ff <= cpu_rd ? nxt_rdata : 8'h00;
    end

endmodule

// file: testbench/tops_timer_out_monitor.sv
// Purpose: port checker for the timer output block
// Assumes: defs header on the include path
// Notes: bound at the foot of this file
`timescale 1ns/1ps
`include "tops_defs.vh"
module tops_timer_out_monitor (
    // system
    input wire clock,
    input wire rst,
    // cpu port
    input wire [15:0] cpu_addr,
    input wire [7:0] cpu_wdata,
    input wire cpu_wr,
    input wire cpu_rd,
    input wire [7:0] cpu_rdata_ff,
    // core and pins
    input wire count_tick_ff,
    input wire input_b_edge_ff,
    input wire shared_port_pin1_latch,
    input wire timer_output_pin_ff,
    input wire timer_output_pin_oe_ff,
    input wire [7:0] port0_direction_ff
);
default clocking @(posedge clock); endclocking
default disable iff (rst);
wire toc_wr = cpu_wr && cpu_addr == `TOPS_ADDR_TOC;
wire lat = shared_port_pin1_latch;
AST_RST_OUT: assert property (disable iff (1'b0) rst |=> !timer_output_pin_ff)
    else $error("pin high after reset");
AST_DIR_FIXED: assert property (port0_direction_ff[7:2] == 6'h3F)
    else $error("fixed direction bits lost");
AST_OUT_OFF: assert property (toc_wr && !cpu_wdata[0] |=> !timer_output_pin_ff)
    else $error("pin high while output disabled");
AST_FORCE_SET: assert property (toc_wr && cpu_wdata[3:0] == 4'h9 && !lat ##1 !lat |-> timer_output_pin_ff)
    else $error("force set missed");
AST_FORCE_CLR: assert property (toc_wr && cpu_wdata[3:2] == 2'b01 |=> !timer_output_pin_ff)
    else $error("force clear missed");
AST_RD_MASK: assert property (cpu_rd && cpu_addr == `TOPS_ADDR_TOC |=> (cpu_rdata_ff & 8'hCC) == 8'h00)
    else $error("write-only control bits read back");
AST_HOLD: assert property (!cpu_wr && !count_tick_ff && $stable(lat) |=> $stable(timer_output_pin_ff))
    else $error("pin moved without a count cycle");
AST_B_EDGE_OFF: assert property (!cpu_wr && !port0_direction_ff[1] |=> !input_b_edge_ff)
    else $error("input b edge while pin drives");
AST_OE_DIR: assert property (!cpu_wr && $stable(port0_direction_ff) |=> timer_output_pin_oe_ff == !port0_direction_ff[1])
    else $error("output enable disagrees with direction");
COV_SET: cover property (toc_wr && cpu_wdata[3:2] == 2'b10);
COV_TOG: cover property (count_tick_ff ##1 $changed(timer_output_pin_ff));
COV_RD: cover property (cpu_rd ##1 cpu_rdata_ff != 8'h00);
endmodule
bind tops_timer_out tops_timer_out_monitor i_mon (.clock(clock), .rst(rst), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata_ff(cpu_rdata_ff),
    .count_tick_ff(count_tick_ff), .input_b_edge_ff(input_b_edge_ff),
    .shared_port_pin1_latch(shared_port_pin1_latch), .timer_output_pin_ff(timer_output_pin_ff),
    .timer_output_pin_oe_ff(timer_output_pin_oe_ff), .port0_direction_ff(port0_direction_ff));

// file: testbench/tops_core_model.sv
// Purpose: small counter core feeding matches and overflow
// Assumes: 4-bit count so events come often
// Notes: matches gated off while stopped
`timescale 1ns/1ps
`include "tops_defs.vh"
module tops_core_model #(parameter PRI = 4'h5, parameter SEC = 4'h9) (
    // system
    input wire clock,
    input wire rst,
    // block side
    input wire [1:0] mode,
    input wire tick,
    output wire primary_match,
    output wire secondary_match,
    output wire overflow
);
reg [3:0] cnt_ff;
wire run = mode != `TOPS_MODE_STOP;
always @(posedge clock) begin
    if (rst || !run) cnt_ff <= 4'h0;
    else if (tick && mode == `TOPS_MODE_CLR_MATCH && cnt_ff == PRI) cnt_ff <= 4'h0;
    else if (tick) cnt_ff <= cnt_ff + 4'h1;
end
assign primary_match = run && cnt_ff == PRI;
assign secondary_match = run && cnt_ff == SEC;
assign overflow = run && cnt_ff == 4'hF;
endmodule

// file: testbench/test_tops_timer_out.sv
// Purpose: self-checking bench for the timer output block
// Assumes: 20 MHz clock, counter core modelled beside it
// Notes: reads checked from a queue of expected values
`timescale 1ns/1ps
`include "tops_defs.vh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
    $display("FAIL %s exp %h got %h", n, e, g); end end
module test_tops_timer_out;
logic clock = 0;
logic rst = 1;
logic cpu_wr = 0;
logic cpu_rd = 0;
logic tia = 0;
logic tib = 0;
logic latch = 0;
logic rd_q = 0;
logic [15:0] cpu_addr = 16'h0000;
logic [7:0] cpu_wdata = 8'h00;
logic [1:0] mode = 2'h0;
logic [7:0] rdata, dir_ff, d, e, toc;
logic pm, sm, ovf, tick, ea, eb, pin, oe, pin_q;
logic [31:0] rnd = 32'h22BD54BC;
logic [7:0] exp_q[$];
logic [15:0] cfg[3] = '{16'h0003, 16'h0111, 16'h0013};
int err_count = 0;
int cmp_count = 0;
int tog = 0;
int ev = 0;
bit win = 0;
tops_timer_out i_dut (.clock(clock), .rst(rst), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata_ff(rdata), .counter_mode(mode),
    .primary_match(pm), .secondary_match(sm), .counter_overflow(ovf), .count_tick_ff(tick),
    .input_a_edge_ff(ea), .input_b_edge_ff(eb), .timer_input_a(tia), .timer_input_b(tib),
    .shared_port_pin1_latch(latch), .timer_output_pin_ff(pin),
    .timer_output_pin_oe_ff(oe), .port0_direction_ff(dir_ff));
tops_core_model i_core (.clock(clock), .rst(rst), .mode(mode), .tick(tick),
    .primary_match(pm), .secondary_match(sm), .overflow(ovf));
function automatic logic [31:0] xs();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
endfunction
task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clock);
    if (a == `TOPS_ADDR_TOC) toc = v;
    cpu_addr <= a;
    cpu_wdata <= v;
    cpu_wr <= 1'b1;
    @(posedge clock);
    cpu_wr <= 1'b0;
endtask
task automatic rd(input logic [15:0] a, input logic [7:0] x);
    @(posedge clock);
    exp_q.push_back(x);
    cpu_addr <= a;
    cpu_rd <= 1'b1;
    @(posedge clock);
    cpu_rd <= 1'b0;
endtask
task automatic pinchk(input logic x);
    #1;
    `CHK("pin", x, pin)
endtask
task results;
    $display("compares %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
        $display("NO MISMATCHES");
    end else begin
        $display("MISMATCHES SEEN");
    end
    $finish;
endtask
initial forever #25 clock = ~clock;
// watcher: read data one cycle after the strobe, toggle tally
always @(posedge clock) begin
    void'(xs());
    tia <= rnd[3];
    tib <= rnd[9];
    rd_q <= cpu_rd;
    pin_q <= pin;
    if (rd_q) begin
        e = exp_q.pop_front();
        `CHK("rdata", e, rdata)
    end
    if (win && pin !== pin_q) tog++;
    if (win && tick && ((toc[1] && pm) || (toc[4] && sm))) ev++;
end
initial begin
    #200000;
    err_count++;
    results();
end
initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    rd(`TOPS_ADDR_DIR, `TOPS_RST_DIR);
    rd(`TOPS_ADDR_PRE, 8'h00);
    rd(`TOPS_ADDR_TOC, 8'h00);
    rd(16'h1234, 8'h00);
    wr(`TOPS_ADDR_TOC, 8'h7F);
    rd(`TOPS_ADDR_TOC, 8'h33);
    for (int i = 0; i < 4; i++) begin
        d = xs() & 32'hF3;
        d[6] = d[6] | d[7];
        d[4] = d[4] | d[5];
        wr(`TOPS_ADDR_PRE, d);
        rd(`TOPS_ADDR_PRE, d);
    end
    wr(`TOPS_ADDR_DIR, 8'h00);
    rd(`TOPS_ADDR_DIR, 8'hFC);
    `CHK("oe", 1'b1, oe)
    wr(`TOPS_ADDR_TOC, 8'h01);
    wr(`TOPS_ADDR_TOC, 8'h09);
    pinchk(1'b1);
    wr(`TOPS_ADDR_TOC, 8'h00);
    pinchk(1'b0);
    wr(`TOPS_ADDR_TOC, 8'h01);
    pinchk(1'b1);
    latch <= 1'b1;
    repeat (2) @(posedge clock);
    pinchk(1'b0);
    latch <= 1'b0;
    wr(`TOPS_ADDR_TOC, 8'h05);
    pinchk(1'b0);
    foreach (cfg[k]) begin
        wr(`TOPS_ADDR_PRE, cfg[k][15:8]);
        wr(`TOPS_ADDR_TOC, cfg[k][7:0]);
        tog = 0;
        ev = 0;
        win = 1;
        mode <= `TOPS_MODE_FREE;
        repeat (200) @(posedge clock);
        mode <= `TOPS_MODE_STOP;
        repeat (4) @(posedge clock);
        win = 0;
        `CHK("toggles", ev, tog)
        `CHK("events", 1'b1, ev > 0)
    end
    // one-shot: no pulse until triggered, then one edge at overflow
    wr(`TOPS_ADDR_TOC, 8'h21);
    tog = 0;
    win = 1;
    mode <= `TOPS_MODE_FREE;
    repeat (40) @(posedge clock);
    `CHK("idle toggles", 0, tog)
    wr(`TOPS_ADDR_TOC, 8'h61);
    repeat (40) @(posedge clock);
    `CHK("shot toggles", 1, tog)
    mode <= `TOPS_MODE_STOP;
    @(posedge clock);
    tog = 0;
    wr(`TOPS_ADDR_TOC, 8'h61);
    mode <= `TOPS_MODE_CLR_MATCH;
    repeat (40) @(posedge clock);
    `CHK("blocked toggles", 0, tog)
    win = 0;
    results();
end
endmodule
